// File: include/bmc_pkg.sv
// Package for the bridge miscellaneous configuration register bank.
// Assumes byte-wide configuration accesses decoded by an 8-bit register index.
package bmc_pkg;
  // Register offsets
  localparam logic [7:0] OFS_DMA_SIDE = 8'h71;
  localparam logic [7:0] OFS_SEL_SYNC = 8'h72;
  localparam logic [7:0] OFS_DDMA_BASE = 8'h73;
  localparam logic [7:0] OFS_USB_MISC = 8'h74;
  localparam logic [7:0] OFS_IDE_STEER = 8'h75;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Writable bit masks; reserved bits read as zero
  localparam logic [7:0] MSK_DMA_SIDE = 8'hef;
  localparam logic [7:0] MSK_SEL_SYNC = 8'hef;
  localparam logic [7:0] MSK_DDMA_BASE = 8'hff;
  localparam logic [7:0] MSK_USB_MISC = 8'hdf;
  localparam logic [7:0] MSK_IDE_STEER = 8'h1f;
  // Field positions
  localparam int BIT_IRQ_SYNC = 7;
  localparam int BIT_PWREN_GPIO = 6;
  localparam int BIT_SER_REPEAT = 5;
  localparam int POS_PM_SEL = 2;
  localparam int POS_USB_SEL = 0;
  localparam int BIT_IOCHRDY_OFF = 7;
  localparam int BIT_SUBSYS_RO = 6;
  localparam int BIT_EDGE = 4;
  localparam int POS_ROUTE = 0;
  // Address lines used as configuration selects
  localparam int PM_LINE_0 = 28;
  localparam int PM_LINE_1 = 29;
  localparam int PM_LINE_2 = 14;
  localparam int PM_LINE_3 = 15;
  localparam int USB_LINE_0 = 31;
  localparam int USB_LINE_1 = 30;
  localparam int USB_LINE_2 = 13;
  localparam int USB_LINE_3 = 12;
  // Routing codes
  localparam logic [3:0] RT_NONE = 4'h0;
  localparam logic [3:0] RT_IRQ9 = 4'h1;
  localparam logic [3:0] RT_IRQ3 = 4'h2;
  localparam logic [3:0] RT_IRQ10 = 4'h3;
  localparam logic [3:0] RT_IRQ4 = 4'h4;
  localparam logic [3:0] RT_IRQ5 = 4'h5;
  localparam logic [3:0] RT_IRQ7 = 4'h6;
  localparam logic [3:0] RT_IRQ6 = 4'h7;
  localparam logic [3:0] RT_IRQ1 = 4'h8;
  localparam logic [3:0] RT_IRQ11 = 4'h9;
  localparam logic [3:0] RT_IRQ12 = 4'hb;
  localparam logic [3:0] RT_IRQ14 = 4'hd;
  localparam logic [3:0] RT_IRQ15 = 4'hf;
  localparam logic [3:0] RT_RSV_A = 4'ha;
  localparam logic [3:0] RT_RSV_C = 4'hc;
  localparam logic [3:0] RT_RSV_E = 4'he;
  localparam int NUM_IRQ = 16;
endpackage : bmc_pkg

// File: src/bmc_regs.sv
// Miscellaneous configuration register bank of the PCI-to-ISA bridge.
// Assumes a byte-wide configuration access port clocked by the PCI clock and
// active-high interrupt request levels from the internal USB and IDE functions.
`timescale 1ns/100ps

// Notes on behaviour
// - Bits 0-3,5-7 at 71h put each DMA channel on ISA (0) or PCI (1).
// - 72h bit 7 registers steered IRQ outputs on the clock, else bypasses.
// - 72h bit 6 drives USB port power enable onto GPIO pin 7.
// - 72h bit 5 enables repeat of serial IRQ continuous mode.
// - 72h bits 3-2 pick power-management select line: A28, A29, A14, A15.
// - 72h bits 1-0 pick USB select line while USB enabled: A31, A30, A13, A12.
// - 73h holds the 8-bit distributed DMA base address, reset zero.
// - 74h bit 7 set stops driving the ISA ready line during DMA.
// - 74h bit 6 set makes subsystem identity registers read-only.
// - 74h bit 4 turns the USB interrupt level into an edge pulse.
// - 74h bits 3-0 steer the USB interrupt onto an IRQ line.
// - 75h bit 4 turns the IDE secondary interrupt into an edge; 7-5 reserved.
// - 75h bits 3-0 steer the IDE secondary interrupt; 0000 disables it.
module bmc_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [31:0] cfg_ad,
  input wire logic usb_fn_enabled,
  output logic pm_idsel_hit,
  output logic usb_idsel_hit,
  output logic [7:0] dma_on_pci,
  output logic [7:0] ddma_base,
  output logic serirq_repeat_en,
  output logic iochrdy_dma_drive_en,
  output logic subsys_id_wr_en,
  input wire logic usb_port_power_enable_n,
  output logic gpio7_out,
  output logic gpio7_oe,
  input wire logic usb_host_irq_line,
  input wire logic ide_secondary_irq_line,
  output logic [15:0] irq_out
);

  logic [7:0] dma_side_ff, nxt_dma_side;
  logic [7:0] sel_sync_ff, nxt_sel_sync;
  logic [7:0] ddma_base_ff, nxt_ddma_base;
  logic [7:0] usb_misc_ff, nxt_usb_misc;
  logic [7:0] ide_steer_ff, nxt_ide_steer;
  logic [7:0] rdata_ff, nxt_rdata;
  logic usb_prev_ff, nxt_usb_prev;
  logic ide_prev_ff, nxt_ide_prev;
  logic [15:0] irq_sync_ff, nxt_irq_sync;
  logic usb_src, ide_src;
  logic [15:0] routed;

  // Steering map shared by both interrupt sources
  function automatic logic [15:0] bmc_route(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    unique case (code)
      bmc_pkg::RT_IRQ9: v[9] = 1'b1;
      bmc_pkg::RT_IRQ3: v[3] = 1'b1;
      bmc_pkg::RT_IRQ10: v[10] = 1'b1;
      bmc_pkg::RT_IRQ4: v[4] = 1'b1;
      bmc_pkg::RT_IRQ5: v[5] = 1'b1;
      bmc_pkg::RT_IRQ7: v[7] = 1'b1;
      bmc_pkg::RT_IRQ6: v[6] = 1'b1;
      bmc_pkg::RT_IRQ1: v[1] = 1'b1;
      bmc_pkg::RT_IRQ11: v[11] = 1'b1;
      bmc_pkg::RT_IRQ12: v[12] = 1'b1;
      bmc_pkg::RT_IRQ14: v[14] = 1'b1;
      bmc_pkg::RT_IRQ15: v[15] = 1'b1;
      // None and reserved codes route nowhere
      bmc_pkg::RT_NONE, bmc_pkg::RT_RSV_A, bmc_pkg::RT_RSV_C,
      bmc_pkg::RT_RSV_E: v = 16'h0000;
    endcase
    return v;
  endfunction : bmc_route

  // Register writes and reads
  always_comb begin
    nxt_dma_side = dma_side_ff;
    nxt_sel_sync = sel_sync_ff;
    nxt_ddma_base = ddma_base_ff;
    nxt_usb_misc = usb_misc_ff;
    nxt_ide_steer = ide_steer_ff;
    nxt_rdata = rdata_ff;
    if (cfg_wr) begin
      unique case (cfg_index)
        bmc_pkg::OFS_DMA_SIDE: nxt_dma_side = cfg_wdata & bmc_pkg::MSK_DMA_SIDE;
        bmc_pkg::OFS_SEL_SYNC: nxt_sel_sync = cfg_wdata & bmc_pkg::MSK_SEL_SYNC;
        bmc_pkg::OFS_DDMA_BASE: nxt_ddma_base = cfg_wdata & bmc_pkg::MSK_DDMA_BASE;
        bmc_pkg::OFS_USB_MISC: nxt_usb_misc = cfg_wdata & bmc_pkg::MSK_USB_MISC;
        bmc_pkg::OFS_IDE_STEER: nxt_ide_steer = cfg_wdata & bmc_pkg::MSK_IDE_STEER;
        default: nxt_rdata = rdata_ff;
      endcase
    end
    if (cfg_rd) begin
      unique case (cfg_index)
        bmc_pkg::OFS_DMA_SIDE: nxt_rdata = dma_side_ff;
        bmc_pkg::OFS_SEL_SYNC: nxt_rdata = sel_sync_ff;
        bmc_pkg::OFS_DDMA_BASE: nxt_rdata = ddma_base_ff;
        bmc_pkg::OFS_USB_MISC: nxt_rdata = usb_misc_ff;
        bmc_pkg::OFS_IDE_STEER: nxt_rdata = ide_steer_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dma_side_ff <= bmc_pkg::RST_VAL;
      sel_sync_ff <= bmc_pkg::RST_VAL;
      ddma_base_ff <= bmc_pkg::RST_VAL;
      usb_misc_ff <= bmc_pkg::RST_VAL;
      ide_steer_ff <= bmc_pkg::RST_VAL;
      rdata_ff <= 8'h00;
    end else begin
      dma_side_ff <= nxt_dma_side;
      sel_sync_ff <= nxt_sel_sync;
      ddma_base_ff <= nxt_ddma_base;
      usb_misc_ff <= nxt_usb_misc;
      ide_steer_ff <= nxt_ide_steer;
      rdata_ff <= nxt_rdata;
    end
  end

  // Registered read data costs a cycle but keeps the returned byte glitch-free
  assign cfg_rdata = rdata_ff;
  assign dma_on_pci = dma_side_ff;
  assign ddma_base = ddma_base_ff;
  assign serirq_repeat_en = sel_sync_ff[bmc_pkg::BIT_SER_REPEAT];
  assign iochrdy_dma_drive_en = ~usb_misc_ff[bmc_pkg::BIT_IOCHRDY_OFF];
  assign subsys_id_wr_en = ~usb_misc_ff[bmc_pkg::BIT_SUBSYS_RO];

  // Power enable is active low, so the pin copies it uninverted while 72h bit 6 is set and is held low otherwise
  assign gpio7_oe = sel_sync_ff[bmc_pkg::BIT_PWREN_GPIO];
  assign gpio7_out = gpio7_oe & usb_port_power_enable_n;

  // Configuration-select decode from the chosen address line
  always_comb begin
    unique case (sel_sync_ff[bmc_pkg::POS_PM_SEL +: 2])
      2'h0: pm_idsel_hit = cfg_ad[bmc_pkg::PM_LINE_0];
      2'h1: pm_idsel_hit = cfg_ad[bmc_pkg::PM_LINE_1];
      2'h2: pm_idsel_hit = cfg_ad[bmc_pkg::PM_LINE_2];
      2'h3: pm_idsel_hit = cfg_ad[bmc_pkg::PM_LINE_3];
    endcase
    unique case (sel_sync_ff[bmc_pkg::POS_USB_SEL +: 2])
      2'h0: usb_idsel_hit = usb_fn_enabled & cfg_ad[bmc_pkg::USB_LINE_0];
      2'h1: usb_idsel_hit = usb_fn_enabled & cfg_ad[bmc_pkg::USB_LINE_1];
      2'h2: usb_idsel_hit = usb_fn_enabled & cfg_ad[bmc_pkg::USB_LINE_2];
      2'h3: usb_idsel_hit = usb_fn_enabled & cfg_ad[bmc_pkg::USB_LINE_3];
    endcase
  end

  // Level-to-edge conversion and steering
  always_comb begin
    nxt_usb_prev = usb_host_irq_line;
    nxt_ide_prev = ide_secondary_irq_line;
    usb_src = usb_misc_ff[bmc_pkg::BIT_EDGE] ? (usb_host_irq_line & ~usb_prev_ff)
                                             : usb_host_irq_line;
    ide_src = ide_steer_ff[bmc_pkg::BIT_EDGE] ? (ide_secondary_irq_line & ~ide_prev_ff)
                                              : ide_secondary_irq_line;
    routed = (bmc_route(usb_misc_ff[bmc_pkg::POS_ROUTE +: 4]) & {16{usb_src}})
           | (bmc_route(ide_steer_ff[bmc_pkg::POS_ROUTE +: 4]) & {16{ide_src}});
    nxt_irq_sync = routed;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      usb_prev_ff <= 1'b0;
      ide_prev_ff <= 1'b0;
      irq_sync_ff <= 16'h0000;
    end else begin
      usb_prev_ff <= nxt_usb_prev;
      ide_prev_ff <= nxt_ide_prev;
      irq_sync_ff <= nxt_irq_sync;
    end
  end

  // Bypass saves a cycle of latency but passes input glitches straight out
  assign irq_out = sel_sync_ff[bmc_pkg::BIT_IRQ_SYNC] ? irq_sync_ff : routed;

  // Checks
  dma_side_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_index == bmc_pkg::OFS_DMA_SIDE
    |=> dma_on_pci == ($past(cfg_wdata) & 8'hef))
    else $error("DMA side register not updated");
  irq_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_sync_ff[bmc_pkg::BIT_IRQ_SYNC] && $stable(sel_sync_ff)
    |-> irq_out == $past(routed))
    else $error("Synchronised IRQ output does not lag routing by one cycle");
  irq_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
    usb_src && usb_misc_ff[3:0] == 4'h1 && !sel_sync_ff[7] |-> irq_out[9])
    else $error("Bypassed IRQ output not immediate");
  gpio7_pwren_a: assert property (@(posedge ref_clk) disable iff (rst)
    gpio7_oe == sel_sync_ff[6] && (!gpio7_oe || gpio7_out == usb_port_power_enable_n))
    else $error("GPIO 7 power enable mismatch");
  repeat_en_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_index == bmc_pkg::OFS_SEL_SYNC |=> serirq_repeat_en == $past(cfg_wdata[5]))
    else $error("Serial IRQ repeat enable wrong");
  pm_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_sync_ff[3:2] == 2'h2 |-> pm_idsel_hit == cfg_ad[14])
    else $error("Power-management select line wrong");
  usb_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!usb_fn_enabled |-> !usb_idsel_hit) and
    (usb_fn_enabled && sel_sync_ff[1:0] == 2'h3 |-> usb_idsel_hit == cfg_ad[12]))
    else $error("USB select line wrong");
  ddma_base_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_index == bmc_pkg::OFS_DDMA_BASE |=> ddma_base == $past(cfg_wdata))
    else $error("Distributed DMA base not stored");
  iochrdy_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_index == bmc_pkg::OFS_USB_MISC |=> iochrdy_dma_drive_en == !$past(cfg_wdata[7]))
    else $error("Ready drive control wrong");
  subsys_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
    subsys_id_wr_en != usb_misc_ff[6])
    else $error("Subsystem identity write control wrong");
  usb_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    usb_misc_ff[4] && $stable(usb_misc_ff) && usb_src |=> !usb_src)
    else $error("USB edge pulse longer than one cycle");
  ide_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    ide_steer_ff[4] && $stable(ide_steer_ff) && ide_src |=> !ide_src)
    else $error("IDE edge pulse longer than one cycle");
  ide_route_a: assert property (@(posedge ref_clk) disable iff (rst)
    ide_src && ide_steer_ff[3:0] == 4'h2 |-> routed[3])
    else $error("IDE interrupt not on IRQ3");
  reserved_none_a: assert property (@(posedge ref_clk) disable iff (rst)
    usb_misc_ff[3:0] inside {4'ha, 4'hc, 4'he, 4'h0} && ide_steer_ff[3:0] inside {4'hc, 4'h0}
    |-> routed == 16'h0000)
    else $error("Reserved code drives an IRQ line");
  reg_reset_a: assert property (@(posedge ref_clk) rst |=> dma_on_pci == 8'h00 &&
    ddma_base == 8'h00 && irq_out == 16'h0000)
    else $error("Registers not cleared by reset");

  // Register reads and writes
  read_back_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd && cfg_index == bmc_pkg::OFS_DDMA_BASE
    |=> cfg_rdata == $past(ddma_base_ff))
    else $error("Read of distributed DMA base wrong");
  side_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd && cfg_index == bmc_pkg::OFS_DMA_SIDE
    |=> cfg_rdata == $past(dma_side_ff))
    else $error("Read of DMA side register wrong");
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd && !(cfg_index inside {[bmc_pkg::OFS_DMA_SIDE:bmc_pkg::OFS_IDE_STEER]})
    |=> cfg_rdata == 8'h00)
    else $error("Unmapped index reads non-zero");
  rdata_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("Read data changed without a read");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    !dma_side_ff[4] && !sel_sync_ff[4] && !usb_misc_ff[5] && ide_steer_ff[7:5] == 3'h0)
    else $error("Reserved register bit set");
  subsys_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_index == bmc_pkg::OFS_USB_MISC |=> subsys_id_wr_en == !$past(cfg_wdata[6]))
    else $error("Subsystem identity lock not updated");
  gpio_en_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_index == bmc_pkg::OFS_SEL_SYNC |=> gpio7_oe == $past(cfg_wdata[6]))
    else $error("GPIO 7 enable not updated");
  ide_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr && cfg_index == bmc_pkg::OFS_IDE_STEER
    |=> ide_steer_ff == ($past(cfg_wdata) & bmc_pkg::MSK_IDE_STEER))
    else $error("IDE steering register not updated");

  // Select decode
  pm_default_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_sync_ff[3:2] == 2'h0 |-> pm_idsel_hit == cfg_ad[28])
    else $error("Power-management default select line wrong");
  pm_alt_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_sync_ff[3:2] == 2'h1 |-> pm_idsel_hit == cfg_ad[29])
    else $error("Power-management alternate select line wrong");
  usb_default_a: assert property (@(posedge ref_clk) disable iff (rst)
    usb_fn_enabled && sel_sync_ff[1:0] == 2'h0 |-> usb_idsel_hit == cfg_ad[31])
    else $error("USB default select line wrong");
  usb_alt_a: assert property (@(posedge ref_clk) disable iff (rst)
    usb_fn_enabled && sel_sync_ff[1:0] == 2'h2 |-> usb_idsel_hit == cfg_ad[13])
    else $error("USB alternate select line wrong");

  // Interrupt path and GPIO 7 gating
  usb_route_a: assert property (@(posedge ref_clk) disable iff (rst)
    usb_src && usb_misc_ff[3:0] == 4'hd |-> routed[14])
    else $error("USB interrupt not on IRQ14");
  route_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    !usb_src && !ide_src |-> routed == 16'h0000)
    else $error("IRQ line driven with no request");
  route_map_a: assert property (@(posedge ref_clk) disable iff (rst)
    ide_src && ide_steer_ff[3:0] == 4'h6 |-> routed[7])
    else $error("IDE interrupt not on IRQ7");
  route_irq1_a: assert property (@(posedge ref_clk) disable iff (rst)
    usb_src && usb_misc_ff[3:0] == 4'h8 |-> routed[1])
    else $error("USB interrupt not on IRQ1");
  gpio7_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !gpio7_oe |-> !gpio7_out)
    else $error("GPIO 7 carries power enable while disabled");
  usb_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    !usb_misc_ff[4] |-> usb_src == usb_host_irq_line)
    else $error("USB level not passed through");
  ide_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    !ide_steer_ff[4] |-> ide_src == ide_secondary_irq_line)
    else $error("IDE level not passed through");

  usb_irq_c: cover property (@(posedge ref_clk) disable iff (rst) usb_src && |irq_out);
  ide_irq_c: cover property (@(posedge ref_clk) disable iff (rst) ide_src && |irq_out);
  sync_on_c: cover property (@(posedge ref_clk) disable iff (rst) sel_sync_ff[7] && |irq_out);
  gpio7_c: cover property (@(posedge ref_clk) disable iff (rst) gpio7_oe);
  edge_pulse_c: cover property (@(posedge ref_clk) disable iff (rst) usb_misc_ff[4] && usb_src);

endmodule : bmc_regs

// File: tb/bmc_far_side.sv
// Far side of the register bank: the internal USB and IDE interrupt sources and the USB
// port power switch. Assumes the bench steers it a little after each rising clock edge.
`timescale 1ns/100ps
module bmc_far_side (
  input wire logic usb_req,
  input wire logic ide_req,
  input wire logic pwr_on,
  output logic usb_host_irq_line,
  output logic ide_secondary_irq_line,
  output logic usb_port_power_enable_n
);
  // Requests are plain active-high levels held for as long as the source wants service
  assign usb_host_irq_line = usb_req;
  assign ide_secondary_irq_line = ide_req;
  // Power switch request is active low on the wire
  assign usb_port_power_enable_n = ~pwr_on;
endmodule : bmc_far_side

// File: tb/bmc_regs_bench.sv
// Self-checking bench for the bridge configuration register bank.
// Assumes the byte access port answers one edge after a strobe.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module bmc_regs_bench;
  logic ref_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, usb_fn_enabled = 1'b0;
  logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, cfg_rdata, dma_on_pci, ddma_base;
  logic [31:0] cfg_ad = 32'h0;
  logic pm_idsel_hit, usb_idsel_hit, serirq_repeat_en, iochrdy_dma_drive_en, subsys_id_wr_en;
  logic gpio7_out, gpio7_oe, usb_req = 1'b0, ide_req = 1'b0, pwr_on = 1'b0;
  logic usb_host_irq_line, ide_secondary_irq_line, usb_port_power_enable_n;
  logic [15:0] irq_out;
  int n_errors = 0, n_checks = 0;
  // Rows: index, value written, value read back (reserved bits drop, unmapped reads zero)
  logic [7:0] r_idx[6] = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h70};
  logic [7:0] r_wd[6] = '{8'hff, 8'h1f, 8'ha5, 8'h20, 8'hff, 8'hff};
  logic [7:0] r_rd[6] = '{8'hef, 8'h0f, 8'ha5, 8'h00, 8'h1f, 8'h00};
  int irq_map[16] = '{-1, 9, 3, 10, 4, 5, 7, 6, 1, 11, -1, 12, -1, 14, -1, 15};
  int pm_line[4] = '{28, 29, 14, 15};
  int usb_line[4] = '{31, 30, 13, 12};
  logic [15:0] exp_irq;
  always #4 ref_clk = ~ref_clk;
  bmc_far_side u_bmc_far_side (.usb_req(usb_req), .ide_req(ide_req), .pwr_on(pwr_on),
    .usb_host_irq_line(usb_host_irq_line), .ide_secondary_irq_line(ide_secondary_irq_line),
    .usb_port_power_enable_n(usb_port_power_enable_n));
  bmc_regs u_bmc_regs (.ref_clk(ref_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ad(cfg_ad),
    .usb_fn_enabled(usb_fn_enabled), .pm_idsel_hit(pm_idsel_hit),
    .usb_idsel_hit(usb_idsel_hit), .dma_on_pci(dma_on_pci), .ddma_base(ddma_base),
    .serirq_repeat_en(serirq_repeat_en), .iochrdy_dma_drive_en(iochrdy_dma_drive_en),
    .subsys_id_wr_en(subsys_id_wr_en), .usb_port_power_enable_n(usb_port_power_enable_n),
    .gpio7_out(gpio7_out), .gpio7_oe(gpio7_oe), .usb_host_irq_line(usb_host_irq_line),
    .ide_secondary_irq_line(ide_secondary_irq_line), .irq_out(irq_out));
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step
  // One idle cycle between accesses so a strobe is never lowered and raised in one step
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    step();
    cfg_index = i;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    step();
    cfg_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
    step();
    cfg_index = i;
    cfg_rd = 1'b1;
    step();
    cfg_rd = 1'b0;
    `CHK("cfg_rdata", e, cfg_rdata)
  endtask : rd_chk
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (6) step();
    rst = 1'b0;
    for (int r = 0; r < 6; r++) begin
      wr(r_idx[r], r_wd[r]);
      rd_chk(r_idx[r], r_rd[r]);
    end
    `CHK("dma_on_pci", 8'hef, dma_on_pci)
    `CHK("ddma_base", 8'ha5, ddma_base)
    `CHK("serirq_repeat_en", 1'b0, serirq_repeat_en)
    wr(8'h74, 8'hc0);
    `CHK("iochrdy_dma_drive_en", 1'b0, iochrdy_dma_drive_en)
    `CHK("subsys_id_wr_en", 1'b0, subsys_id_wr_en)
    wr(8'h72, 8'h60);
    `CHK("serirq_repeat_en", 1'b1, serirq_repeat_en)
    `CHK("gpio7_oe", 1'b1, gpio7_oe)
    pwr_on = 1'b1;
    #1 `CHK("gpio7_out", 1'b0, gpio7_out)
    step();
    pwr_on = 1'b0;
    #1 `CHK("gpio7_out", 1'b1, gpio7_out)
    for (int s = 0; s < 4; s++) begin
      wr(8'h72, 8'((s << 2) | s));
      usb_fn_enabled = 1'b1;
      cfg_ad = 32'h1 << pm_line[s];
      #1 `CHK("pm_idsel_hit", 1'b1, pm_idsel_hit)
      step();
      cfg_ad = 32'h1 << usb_line[s];
      #1 `CHK("usb_idsel_hit", 1'b1, usb_idsel_hit)
      step();
      cfg_ad = ~cfg_ad;
      #1 `CHK("usb_idsel_hit", 1'b0, usb_idsel_hit)
      step();
      cfg_ad = 32'h1 << usb_line[s];
      usb_fn_enabled = 1'b0;
      #1 `CHK("usb_idsel_hit", 1'b0, usb_idsel_hit)
      step();
      cfg_ad = ~(32'h1 << pm_line[s]);
      #1 `CHK("pm_idsel_hit", 1'b0, pm_idsel_hit)
    end
    // Power enable asserted while the pin is disabled must not reach it
    step();
    pwr_on = 1'b1;
    #1 `CHK("gpio7_oe", 1'b0, gpio7_oe)
    `CHK("gpio7_out", 1'b0, gpio7_out)
    step();
    pwr_on = 1'b0;
    // Routing in bypass: USB codes first, then IDE codes with the USB route off
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 16; c++) begin
        wr(p ? 8'h75 : 8'h74, 8'(c));
        exp_irq = (irq_map[c] < 0) ? 16'h0000 : (16'h0001 << irq_map[c]);
        usb_req = (p == 0);
        ide_req = (p == 1);
        #1 `CHK("irq_out", exp_irq, irq_out)
        step();
        usb_req = 1'b0;
        ide_req = 1'b0;
      end
      wr(8'h74, 8'h00);
    end
    // Edge mode pulses for one cycle only while the level stays high
    wr(8'h75, 8'h12);
    step();
    ide_req = 1'b1;
    #1 `CHK("irq_out", 16'h0008, irq_out)
    step();
    `CHK("irq_out", 16'h0000, irq_out)
    ide_req = 1'b0;
    wr(8'h74, 8'h11);
    step();
    usb_req = 1'b1;
    #1 `CHK("irq_out", 16'h0200, irq_out)
    step();
    `CHK("irq_out", 16'h0000, irq_out)
    usb_req = 1'b0;
    // Sync stage delays the routed level by one clock
    wr(8'h74, 8'h01);
    wr(8'h72, 8'h80);
    step();
    usb_req = 1'b1;
    #1 `CHK("irq_out", 16'h0000, irq_out)
    step();
    `CHK("irq_out", 16'h0200, irq_out)
    usb_req = 1'b0;
    // A read and a write of one index in one cycle return the old value
    step();
    cfg_index = 8'h73;
    cfg_wdata = 8'h3c;
    cfg_wr = 1'b1;
    cfg_rd = 1'b1;
    step();
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    `CHK("cfg_rdata", 8'ha5, cfg_rdata)
    `CHK("ddma_base", 8'h3c, ddma_base)
    // Second reset in mid-run clears every register, even with both requests high
    wr(8'h71, 8'h5a);
    `CHK("dma_on_pci", 8'h4a, dma_on_pci)
    usb_req = 1'b1;
    ide_req = 1'b1;
    rst = 1'b1;
    step();
    step();
    rst = 1'b0;
    for (int r = 0; r < 5; r++) rd_chk(r_idx[r], 8'h00);
    `CHK("iochrdy_dma_drive_en", 1'b1, iochrdy_dma_drive_en)
    `CHK("subsys_id_wr_en", 1'b1, subsys_id_wr_en)
    `CHK("irq_out", 16'h0000, irq_out)
    complete_run();
  end
endmodule : bmc_regs_bench
